// file: hdl/asc_map.svh
// constants for the converter control ends: commands, fields, counts, host register map
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

// ************************************************************
// serial commands (upper nibble of a frame)
// ************************************************************
`define CMD_IN_HI   4'h7
`define CMD_CFG     4'hA
`define CMD_TEST_LO 4'hB
`define CMD_TEST_HI 4'hD
`define CMD_RDFIFO  4'hE
`define CMD_BITS    5'h04
`define FRAME_BITS  5'h10

// ************************************************************
// configuration word fields
// ************************************************************
`define F_THR    0
`define F_ROLE   2
`define F_SWEEP  3
`define F_MODE   5
`define F_CLK    7
`define F_LONG   9
`define F_INTREF 10
`define CFG_RST  12'h000

`define MODE_SINGLE 2'h0
`define MODE_REPEAT 2'h1
`define CLK_OSC     2'h0
`define CLK_SCLK    2'h1
`define CLK_DIV4    2'h2
`define CLK_DIV2    2'h3

// ************************************************************
// timing and depth
// ************************************************************
`define SAMP_SHORT 5'h0C
`define SAMP_LONG  5'h18
`define CONV_CLKS  5'h0E
`define OSC_DIV    8'h19
`define FIFO_FULL  4'h8
`define THR_FULL   4'h8
`define THR_3Q     4'h6
`define THR_HALF   4'h4
`define THR_QTR    4'h2

// ************************************************************
// host controller registers and serial timing
// ************************************************************
`define REG_TX    4'h0
`define REG_RX    4'h4
`define REG_STAT  4'h8
`define REG_PIN   4'hC
`define SCLK_HALF 4'h5
`define GAP_CYC   4'hA
`define FRAME_LEN 6'h10

`endif

// file: hdl/asc_pkg.sv
// types shared by the converter control ends
package asc_pkg;
`include "asc_map.svh"

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_SAMPLE = 4'b0010,
		ST_XSAMP  = 4'b0100,
		ST_CONV   = 4'b1000
	} asc_state_t;

	typedef enum logic [2:0] {
		H_IDLE  = 3'b001,
		H_SHIFT = 3'b010,
		H_GAP   = 3'b100
	} asc_hstate_t;

	typedef struct packed {
		asc_state_t       st;
		logic [11:0]      cfg;
		logic [15:0]      shin;
		logic [4:0]       bits;
		logic [3:0]       cmd_q;
		logic [4:0]       cnt;
		logic [7:0]       osc;
		logic [1:0]       div;
		logic [3:0]       chan;
		logic [2:0]       seq;
		logic             ext;
		logic             pend;
		logic             exit_cnt;
		logic [7:0][11:0] fifo;
		logic [2:0]       wr;
		logic [2:0]       rd;
		logic [3:0]       fill;
		logic [11:0]      obuf;
		logic [15:0]      sho;
		logic             rd_pop;
		logic             intr;
		logic             cs_q;
		logic             sclk_q;
		logic             cst_q;
		logic             sdo;
		logic             sdo_oe;
		logic             status;
	} asc_dev_t;

	typedef struct packed {
		asc_hstate_t st;
		logic [3:0]  hcnt;
		logic [5:0]  nbits;
		logic [5:0]  bitc;
		logic [15:0] tx;
		logic [15:0] rx;
		logic [15:0] rxw;
		logic        sclk;
		logic        cs_n;
		logic        sdi;
		logic        cst_n;
		logic        ack;
		logic [31:0] dat;
	} asc_host_t;

	typedef struct packed {
		logic [1:0] ff;
	} asc_sync_t;
endpackage

// file: hdl/asc_link_if.sv
// serial link between host controller and converter control
`timescale 1ns/1ps
interface asc_link_if;
	logic cs_n;
	logic sclk;
	logic sdi;
	logic sdo;
	logic sdo_oe;
	logic conversion_start_pin_n;
	logic status;
	logic sdo_line;

	// released data line reads high (pull-up)
	assign sdo_line = sdo_oe ? sdo : 1'b1;

	modport dev  (input cs_n, sclk, sdi, conversion_start_pin_n, output sdo, sdo_oe, status);
	modport host (output cs_n, sclk, sdi, conversion_start_pin_n, input sdo_line, status);
endinterface

// file: hdl/asc_sync.sv
// two-flop synchroniser for the asynchronous conversion start pin
`timescale 1ns/1ps
module asc_sync
	import asc_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic async_i,
	output logic      sync_o
);
	asc_sync_t s;
	asc_sync_t next_s;

	// first stage feeds only the second stage
	always_comb begin
		next_s.ff = {s.ff[0], async_i};
	end

	// pin idles high, so reset to high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s.ff <= 2'h3;
		end else begin
			s <= next_s;
		end
	end

	assign sync_o = s.ff[1];
endmodule

// file: hdl/asc_dev.sv
// converter end: command decode, sampling window timing, conversion timing, result buffer
`timescale 1ns/1ps
`include "asc_map.svh"
module asc_dev
	import asc_pkg::*;
#(
	parameter bit QUAD = 1'b0
)(
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	asc_link_if.dev    lk,
	input  wire logic [11:0] result_i,
	output logic [3:0] mux_o,
	output logic       sample_o,
	output logic       convert_o,
	output logic       ext_mode_o
);
	// ************************************************************
	// decode helpers
	// ************************************************************

	// sweep order: input for a given step of the sequence
	function automatic logic [3:0] seq_chan(input logic [1:0] code, input logic [2:0] idx);
		logic [3:0] c;
		c = 4'h0;
		if (QUAD) begin
			case (code)
				2'h2:    c = {2'h0, idx[2:1]};
				2'h3:    c = {3'h0, idx[0]};
				default: c = {2'h0, idx[1:0]};
			endcase
		end else begin
			case (code)
				2'h0:    c = {1'b0, idx};
				2'h1:    c = {1'b0, idx[1:0], 1'b0};
				2'h2:    c = {1'b0, idx[2:1], 1'b0};
				default: c = {2'h0, idx[0], 1'b0};
			endcase
		end
		return c;
	endfunction

	// fill level at which a sweep raises its interrupt
	function automatic logic [3:0] thr_level(input logic [1:0] code);
		logic [3:0] t;
		t = `THR_FULL;
		case (code)
			2'h1:    t = `THR_3Q;
			2'h2:    t = `THR_HALF;
			2'h3:    t = `THR_QTR;
			default: t = `THR_FULL;
		endcase
		return t;
	endfunction

	// ************************************************************
	// state and edge detection
	// ************************************************************
	asc_dev_t   s;
	asc_dev_t   next_s;
	logic       cst;
	logic       cs_fall;
	logic       cs_rise;
	logic       sc_rise;
	logic       sc_fall;
	logic       cst_fall;
	logic       cst_rise;
	logic [1:0] mode;
	logic [3:0] cmd;
	logic       is_in;
	logic       is_conv;
	logic       cst_ok;
	logic       tick;
	logic [4:0] samp_len;
	logic [11:0] rd_word;

	// start pin is asynchronous to everything here
	asc_sync u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (lk.conversion_start_pin_n),
		.sync_o  (cst)
	);

	// edges of the pins against their last sampled level
	assign cs_fall  = s.cs_q & ~lk.cs_n;
	assign cs_rise  = ~s.cs_q & lk.cs_n;
	assign sc_rise  = ~s.sclk_q & lk.sclk;
	assign sc_fall  = s.sclk_q & ~lk.sclk;
	assign cst_fall = s.cst_q & ~cst;
	assign cst_rise = ~s.cst_q & cst;

	// configuration decode
	assign mode     = s.cfg[`F_MODE +: 2];
	assign cmd      = {s.shin[2:0], lk.sdi};
	assign is_in    = cmd <= `CMD_IN_HI;
	assign is_conv  = is_in | ((cmd >= `CMD_TEST_LO) & (cmd <= `CMD_TEST_HI));
	assign cst_ok   = (mode == `MODE_SINGLE) | s.cfg[`F_INTREF];
	assign samp_len = s.cfg[`F_LONG] ? `SAMP_LONG : `SAMP_SHORT;
	assign rd_word  = (mode == `MODE_SINGLE) ? s.obuf : s.fifo[s.rd];

	// conversion clock enable from the selected source
	always_comb begin
		case (s.cfg[`F_CLK +: 2])
			`CLK_OSC:  tick = (s.osc == 8'h00);
			`CLK_SCLK: tick = sc_rise;
			`CLK_DIV4: tick = sc_rise & (s.div == 2'h3);
			default:   tick = sc_rise & s.div[0];
		endcase
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		logic push;
		logic pop;
		logic [3:0] fill_new;
		push     = 1'b0;
		pop      = 1'b0;
		fill_new = 4'h0;
		next_s   = s;
		next_s.cs_q   = lk.cs_n;
		next_s.sclk_q = lk.sclk;
		next_s.cst_q  = cst;
		next_s.osc    = (s.osc == `OSC_DIV - 8'h01) ? 8'h00 : s.osc + 8'h01;

		// frame start: load result, clear interrupt, count exit edges
		if (cs_fall) begin
			next_s.bits   = 5'h00;
			next_s.sho    = {rd_word, 4'h0};
			next_s.sdo    = rd_word[11];
			next_s.sdo_oe = 1'b1;
			next_s.intr   = 1'b0;
			if (s.ext & cst) begin
				if (s.exit_cnt) begin
					next_s.ext      = 1'b0;
					next_s.exit_cnt = 1'b0;
				end else begin
					next_s.exit_cnt = 1'b1;
				end
			end
		end

		// shift in on rising serial clock, decode after four bits
		if (~lk.cs_n & sc_rise & (s.bits != `FRAME_BITS)) begin
			next_s.shin = {s.shin[14:0], lk.sdi};
			next_s.bits = s.bits + 5'h01;
			if (s.bits == `CMD_BITS - 5'h01) begin
				next_s.cmd_q = cmd;
				if (is_conv) begin
					next_s.rd_pop = 1'b1;
					next_s.chan   = cmd;
					if (mode[1] & is_in) begin
						next_s.chan = seq_chan(s.cfg[`F_SWEEP +: 2], s.seq);
						next_s.seq  = s.seq + 3'h1;
					end
					if (~s.ext & (s.st == ST_IDLE)) begin
						next_s.st  = ST_SAMPLE;
						next_s.cnt = 5'h00;
					end
				end else if (cmd == `CMD_RDFIFO) begin
					next_s.rd_pop = 1'b1;
				end
			end
		end

		// shift out on falling serial clock
		if (~lk.cs_n & sc_fall) begin
			next_s.sho = {s.sho[14:0], 1'b0};
			next_s.sdo = s.sho[14];
		end

		// frame end: take configuration, pop read result, start held window
		if (cs_rise) begin
			next_s.sdo_oe = 1'b0;
			next_s.rd_pop = 1'b0;
			if ((s.bits == `FRAME_BITS) & (s.cmd_q == `CMD_CFG)) begin
				next_s.cfg = s.shin[11:0];
			end
			if (s.rd_pop & (mode != `MODE_SINGLE) & (s.fill != 4'h0)) begin
				pop       = 1'b1;
				next_s.rd = s.rd + 3'h1;
			end
			if (s.pend & ~cst & (s.st == ST_IDLE)) begin
				next_s.st   = ST_XSAMP;
				next_s.pend = 1'b0;
			end
		end

		// start pin: falling opens or defers, rising converts
		if (cst_fall & cst_ok) begin
			next_s.ext      = 1'b1;
			next_s.exit_cnt = 1'b0;
			if (lk.cs_n & (s.st == ST_IDLE)) begin
				next_s.st = ST_XSAMP;
			end else begin
				next_s.pend = 1'b1;
			end
		end
		if (cst_rise) begin
			next_s.pend = 1'b0;
			if (s.st == ST_XSAMP) begin
				next_s.st  = ST_CONV;
				next_s.cnt = 5'h00;
				next_s.div = 2'h0;
			end
		end

		// sampling window and conversion timing
		case (s.st)
			ST_SAMPLE: begin
				if (sc_rise) begin
					if (s.cnt == samp_len - 5'h01) begin
						next_s.st  = ST_CONV;
						next_s.cnt = 5'h00;
						next_s.div = 2'h0;
					end else begin
						next_s.cnt = s.cnt + 5'h01;
					end
				end
			end
			ST_CONV: begin
				if (sc_rise) begin
					next_s.div = s.div + 2'h1;
				end
				if (tick) begin
					if (s.cnt == `CONV_CLKS - 5'h01) begin
						next_s.st = ST_IDLE;
						push      = 1'b1;
					end else begin
						next_s.cnt = s.cnt + 5'h01;
					end
				end
			end
			default: begin
			end
		endcase

		// store result: single shot bypasses the fifo
		if (push & (mode == `MODE_SINGLE)) begin
			next_s.obuf = result_i;
			next_s.intr = 1'b1;
			push        = 1'b0;
		end else if (push & (s.fill == `FIFO_FULL)) begin
			push = 1'b0;
		end
		if (push) begin
			next_s.fifo[s.wr] = result_i;
			next_s.wr         = s.wr + 3'h1;
		end
		fill_new    = s.fill + {3'h0, push} - {3'h0, pop};
		next_s.fill = fill_new;
		if (push & (~mode[1] | (fill_new >= thr_level(s.cfg[`F_THR +: 2])))) begin
			next_s.intr = 1'b1;
		end

		// shared status pin: end of conversion high, or interrupt low
		next_s.status = s.cfg[`F_ROLE] ? (next_s.st != ST_CONV) : ~next_s.intr;
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s        <= '0;
			s.st     <= ST_IDLE;
			s.cfg    <= `CFG_RST;
			s.cs_q   <= 1'b1;
			s.cst_q  <= 1'b1;
			s.status <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// outputs and user side, all from state
	assign lk.sdo     = s.sdo;
	assign lk.sdo_oe  = s.sdo_oe;
	assign lk.status  = s.status;
	assign mux_o      = s.chan;
	assign sample_o   = (s.st == ST_SAMPLE) | (s.st == ST_XSAMP);
	assign convert_o  = (s.st == ST_CONV);
	assign ext_mode_o = s.ext;
endmodule

// file: hdl/asc_host.sv
// host end: wishbone registers driving the serial frames and the start pin
`timescale 1ns/1ps
`include "asc_map.svh"
module asc_host
	import asc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	asc_link_if.host         lk
);
	asc_host_t s;
	asc_host_t next_s;

	// bus access and serial frame engine
	always_comb begin
		next_s     = s;
		next_s.ack = 1'b0;

		// one access per request, acknowledged the cycle after it is seen
		if (wb_cyc_i & wb_stb_i & ~s.ack) begin
			next_s.ack = 1'b1;
			next_s.dat = 32'h0000_0000;
			if (wb_we_i) begin
				case (wb_adr_i)
					`REG_TX: begin
						if ((s.st == H_IDLE) & (&wb_sel_i[2:0])) begin
							next_s.st    = H_SHIFT;
							next_s.cs_n  = 1'b0;
							next_s.sclk  = 1'b0;
							next_s.sdi   = wb_dat_i[15];
							next_s.tx    = {wb_dat_i[14:0], 1'b0};
							next_s.nbits = (wb_dat_i[21:16] == 6'h00) ? `FRAME_LEN : wb_dat_i[21:16];
							next_s.bitc  = 6'h00;
							next_s.hcnt  = 4'h0;
						end
					end
					`REG_PIN: begin
						if (wb_sel_i[0]) begin
							next_s.cst_n = wb_dat_i[0];
						end
					end
					default: begin
					end
				endcase
			end else begin
				case (wb_adr_i)
					`REG_RX:   next_s.dat = {16'h0000, s.rxw};
					`REG_STAT: next_s.dat = {30'h0000_0000, lk.status, s.st != H_IDLE};
					`REG_PIN:  next_s.dat = {31'h0000_0000, s.cst_n};
					default:   next_s.dat = 32'h0000_0000;
				endcase
			end
		end

		// serial clock halves: sample on rise, shift or end on fall
		case (s.st)
			H_SHIFT: begin
				if (s.hcnt == `SCLK_HALF - 4'h1) begin
					next_s.hcnt = 4'h0;
					next_s.sclk = ~s.sclk;
					if (~s.sclk) begin
						next_s.rx   = {s.rx[14:0], lk.sdo_line};
						next_s.bitc = s.bitc + 6'h01;
					end else if (s.bitc == s.nbits) begin
						next_s.cs_n = 1'b1;
						next_s.st   = H_GAP;
						next_s.rxw  = s.rx;
					end else begin
						next_s.sdi = s.tx[15];
						next_s.tx  = {s.tx[14:0], 1'b0};
					end
				end else begin
					next_s.hcnt = s.hcnt + 4'h1;
				end
			end
			H_GAP: begin
				if (s.hcnt == `GAP_CYC - 4'h1) begin
					next_s.st   = H_IDLE;
					next_s.hcnt = 4'h0;
				end else begin
					next_s.hcnt = s.hcnt + 4'h1;
				end
			end
			default: begin
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s       <= '0;
			s.st    <= H_IDLE;
			s.cs_n  <= 1'b1;
			s.cst_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign wb_dat_o    = s.dat;
	assign wb_ack_o    = s.ack;
	assign lk.cs_n     = s.cs_n;
	assign lk.sclk     = s.sclk;
	assign lk.sdi      = s.sdi;
	assign lk.conversion_start_pin_n = s.cst_n;
endmodule

// file: tb/asc_sva.sv
// assertions on the converter link: windows, conversion start, extended exit
`timescale 1ns/1ps
module asc_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic conversion_start_pin_n,
	input wire logic sdo_oe,
	input wire logic sample_o,
	input wire logic convert_o,
	input wire logic ext_mode_o
);
	logic [1:0] nfall;
	logic [5:0] nrise;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ************************************************************
	// helper counters
	// ************************************************************
	// select falls with start pin high while extended
	always_ff @(posedge clk_i) begin
		if (rst_i || !ext_mode_o || !conversion_start_pin_n) begin
			nfall <= 2'h0;
		end else if ($fell(cs_n) && nfall != 2'h3) begin
			nfall <= nfall + 2'h1;
		end
	end

	// serial clock rises inside a normal window
	always_ff @(posedge clk_i) begin
		if (rst_i || !sample_o || ext_mode_o) begin
			nrise <= 6'h00;
		end else if ($rose(sclk) && nrise != 6'h3F) begin
			nrise <= nrise + 6'h01;
		end
	end

	// ************************************************************
	// properties
	// ************************************************************
	sequence s_start_fall;
		$fell(conversion_start_pin_n) && cs_n && !sample_o && !convert_o;
	endsequence
	sequence s_second_fall;
		ext_mode_o && conversion_start_pin_n && $fell(cs_n) && nfall == 2'h1;
	endsequence

	property p_open_fall;
		s_start_fall |-> ##[1:6] sample_o;
	endproperty
	a_open_fall: assert property (p_open_fall) else $error("window did not open");
	property p_sync;
		s_start_fall |=> !sample_o;
	endproperty
	a_sync: assert property (p_sync) else $error("window opened unsynchronised");
	property p_xsamp_hold;
		ext_mode_o && sample_o && !conversion_start_pin_n |=> sample_o;
	endproperty
	a_xsamp_hold: assert property (p_xsamp_hold) else $error("window closed early");
	property p_conv_rise;
		ext_mode_o && sample_o && $rose(conversion_start_pin_n) |-> ##[1:6] convert_o;
	endproperty
	a_conv_rise: assert property (p_conv_rise) else $error("no conversion");
	property p_samp_conv;
		$fell(sample_o) |-> ##[0:2] convert_o;
	endproperty
	a_samp_conv: assert property (p_samp_conv) else $error("gap after window");
	property p_defer;
		ext_mode_o && !cs_n && !conversion_start_pin_n && !sample_o |=> !sample_o;
	endproperty
	a_defer: assert property (p_defer) else $error("window opened in frame");
	property p_exit;
		s_second_fall |-> ##[1:4] !ext_mode_o;
	endproperty
	a_exit: assert property (p_exit) else $error("extended mode kept");
	property p_sdo_load;
		$fell(cs_n) |-> ##[1:3] sdo_oe;
	endproperty
	a_sdo_load: assert property (p_sdo_load) else $error("data line not driven");
	property p_win;
		$fell(sample_o) && !ext_mode_o |-> nrise inside {[11:13], [23:25]};
	endproperty
	a_win: assert property (p_win) else $error("normal window length wrong");
endmodule

// file: tb/adc_sampling_config_control_tb.sv
// self-checking bench joining host and converter ends
`timescale 1ns/1ps
module adc_sampling_config_control_tb;
	localparam int SMP = 2;
	localparam int CNV = 1;
	logic        clk_i = 1'b0;
	logic        rst_i;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic [3:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_dat;
	logic [31:0] wb_q;
	logic        wb_ack;
	logic [31:0] q;
	logic [11:0] res;
	logic [3:0]  mux;
	logic        sample;
	logic        convert;
	logic        ext_m;
	int          err_count = 0;
	int          checked = 0;
	logic [15:0] seq8 [4] = '{16'h0123, 16'h0246, 16'h0022, 16'h0202};

	asc_link_if u_asc_link_if ();
	asc_dev #(.QUAD(1'b0)) u_asc_dev (.clk_i(clk_i), .rst_i(rst_i), .lk(u_asc_link_if),
		.result_i(res), .mux_o(mux), .sample_o(sample), .convert_o(convert),
		.ext_mode_o(ext_m));
	asc_host u_asc_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_q), .wb_ack_o(wb_ack), .lk(u_asc_link_if));
	asc_sva u_asc_sva (.clk_i(clk_i), .rst_i(rst_i), .cs_n(u_asc_link_if.cs_n),
		.sclk(u_asc_link_if.sclk), .conversion_start_pin_n(u_asc_link_if.conversion_start_pin_n),
		.sdo_oe(u_asc_link_if.sdo_oe), .sample_o(sample), .convert_o(convert),
		.ext_mode_o(ext_m));

	// free-running 100 MHz clock
	always #5 clk_i = ~clk_i;

	// ************************************************************
	// shared tasks
	// ************************************************************
	task close_out;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task tmo(input string nm);
		err_count++;
		$display("CHECK FAILED %s expected done seen timeout", nm);
		close_out();
	endtask

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one classic cycle, held until ack is sampled
	task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= d;
		@(posedge clk_i);
		while (wb_ack !== 1'b1 && n < 40) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 40) tmo("ack");
		q = wb_q;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask

	// poll busy until the frame and its gap are over
	task idle;
		int n;
		n = 0;
		q = 32'h0000_0001;
		while (q[0] !== 1'b0 && n < 400) begin
			wb(1'b0, 4'h8, 32'h0000_0000);
			n++;
		end
		if (n >= 400) tmo("busy");
	endtask

	task send(input logic [15:0] w, input logic [5:0] n);
		wb(1'b1, 4'h0, {10'h000, n, w});
	endtask

	task frame(input logic [15:0] w, input logic [5:0] n);
		send(w, n);
		idle();
	endtask

	task wait_sig(input int i, input logic v);
		int n;
		logic [2:0] s;
		n = 0;
		@(negedge clk_i);
		s = {sample, convert, ext_m};
		while (s[i] !== v && n < 2000) begin
			@(negedge clk_i);
			s = {sample, convert, ext_m};
			n++;
		end
		if (n >= 2000) tmo("wait");
		// hand back on a rising edge so the next bus cycle starts there
		@(posedge clk_i);
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task t_reset;
		chk("status", {15'h0000, u_asc_link_if.status}, 16'h0001);
		chk("ext", {15'h0000, ext_m}, 16'h0000);
		wb(1'b0, 4'hC, 32'h0000_0000);
		chk("pin", q[15:0], 16'h0001);
	endtask

	// single shot, serial clock, short and long windows, end-of-conversion role
	task t_normal;
		for (int l = 0; l < 2; l++) begin
			res <= l ? 12'hA5C : 12'h3B7;
			// serial clock is 10 MHz, so either window length is allowed here
			frame({4'hA, 2'h0, l[0], 9'h084}, 6'h10);
			send({4'hD, 12'h000}, l ? 6'h30 : 6'h20);
			wait_sig(CNV, 1'b1);
			chk("eoc", {15'h0000, u_asc_link_if.status}, 16'h0000);
			idle();
			chk("conv", {15'h0000, convert}, 16'h0000);
			chk("eoc", {15'h0000, u_asc_link_if.status}, 16'h0001);
			chk("mux", {12'h000, mux}, 16'h000D);
			frame({4'hE, 12'h000}, 6'h10);
			wb(1'b0, 4'h4, 32'h0000_0000);
			chk("rx", q[15:0], {res, 4'h0});
		end
	endtask

	// every sweep order, then the order ignored in single shot
	task t_sweep;
		logic [15:0] tbl;
		tbl = 16'h0000;
		for (int c = 0; c < 4; c++) begin
			tbl = seq8[c];
			frame({4'hA, 3'h0, 2'h1, 2'h2, c[1:0], 3'h0}, 6'h10);
			for (int k = 0; k < 4; k++) begin
				frame(16'h0000, 6'h20);
				chk("sweep", {12'h000, mux}, {12'h000, tbl[15-4*k -: 4]});
			end
		end
		frame({4'hA, 3'h0, 2'h1, 2'h0, 2'h1, 3'h0}, 6'h10);
		frame({4'h3, 12'h000}, 6'h20);
		chk("single", {12'h000, mux}, 16'h0003);
	endtask

	// start pin windows, deferred start, reads and exit
	task t_ext;
		frame({4'hA, 12'h000}, 6'h10);
		res <= 12'h5A3;
		wb(1'b1, 4'hC, 32'h0000_0000);
		wait_sig(SMP, 1'b1);
		chk("ext", {15'h0000, ext_m}, 16'h0001);
		repeat (40) @(posedge clk_i);
		chk("hold", {15'h0000, sample}, 16'h0001);
		wb(1'b1, 4'hC, 32'h0000_0001);
		wait_sig(CNV, 1'b1);
		wait_sig(CNV, 1'b0);
		send({4'h2, 12'h000}, 6'h10);
		wb(1'b1, 4'hC, 32'h0000_0000);
		repeat (20) @(posedge clk_i);
		chk("defer", {15'h0000, sample}, 16'h0000);
		idle();
		wb(1'b0, 4'h4, 32'h0000_0000);
		chk("rx", q[15:0], 16'h5A30);
		res <= 12'hC3E;
		wait_sig(SMP, 1'b1);
		wb(1'b1, 4'hC, 32'h0000_0001);
		wait_sig(CNV, 1'b1);
		wait_sig(CNV, 1'b0);
		frame({4'hE, 12'h000}, 6'h10);
		wb(1'b0, 4'h4, 32'h0000_0000);
		chk("rx", q[15:0], 16'hC3E0);
		frame({4'hA, 12'h000}, 6'h10);
		chk("ext", {15'h0000, ext_m}, 16'h0000);
		frame({4'h7, 12'h000}, 6'h10);
		chk("mux", {12'h000, mux}, 16'h0007);
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		rst_i = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 4'h0;
		wb_sel = 4'hF;
		wb_dat = 32'h0000_0000;
		res = 12'h000;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_normal();
		t_sweep();
		t_ext();
		close_out();
	end
endmodule
